/* File: verilog/int_status_regs.vh */
// How it works
// - Writing one to a clearable status bit clears it; host acknowledges this way.
// - Bit 31 sets whenever the software event enable bit is high; one clears it only once that enable bit is low.
// - Bit 25 sets when stop request is set and the transmitter has halted.
// - Bit 24 sets when the receive engine halts.
// - Bit 23 sets when drop counter steps from 7FFFFFFFh to 80000000h.
// - Bit 21 sets when a notify-marked buffer is fully loaded into transmit FIFO.
// - Bit 20 sets once the programmed receive DMA count has left the FIFO.
// - Bit 19 sets when the general timer wraps from zero to FFFFh.
// - Bit 18 is read-only, mirrors pending PHY event; writes ignored.
// - Bit 17 sets on power event regardless of wake pin; one clears it.
// - Power event never wakes the device; only a byte test write does.
// - Bit 16 sets when the transmit status FIFO overflows.
// - Bit 15 sets when a received packet is longer than 2048 bytes.
// - Bit 14 sets on any receive error condition.
// - Bit 13 sets on any transmit error condition.
// - Bit 11 sets when the transmit data FIFO underruns.
// - Bit 10 sets when host writes a full transmit data FIFO.
// - Bit 9 sets when transmit FIFO free space exceeds programmed level.
// - Bit 8 on transmit status FIFO full, bit 4 on receive status full.
// - Bits 7, 3 set when their status FIFO exceeds programmed level, bit 5 when receive free space falls below it.
// - Bit 6 sets each time a receive frame is dropped.
// - Bits 2..0 latch configured GPIO pin events; one clears each.
// - Status bits other than bit 31 record events whatever the enable mask holds.
// - Master indication is high while any enabled status bit is set.
`ifndef INT_STATUS_REGS_VH
`define INT_STATUS_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_INTERRUPT_STATUS 8'h58
`define OFS_INTERRUPT_ENABLE 8'h5C
`define OFS_BYTE_TEST        8'h64

// ****************************************
// Field positions
// ****************************************
`define BIT_SOFTWARE  31
`define BIT_TX_HALT   25
`define BIT_RX_HALT   24
`define BIT_DROP_MID  23
`define BIT_BUF_LOAD  21
`define BIT_RX_DMA    20
`define BIT_TIMER     19
`define BIT_PHY       18
`define BIT_POWER     17
`define BIT_TXS_OVF   16
`define BIT_RX_WDOG   15
`define BIT_RX_ERR    14
`define BIT_TX_ERR    13
`define BIT_TX_UNDER  11
`define BIT_TX_OVER   10
`define BIT_TX_SPACE  9
`define BIT_TXS_FULL  8
`define BIT_TXS_LEVEL 7
`define BIT_RX_DROP   6
`define BIT_RXD_LEVEL 5
`define BIT_RXS_FULL  4
`define BIT_RXS_LEVEL 3

// ****************************************
// Masks, reset values and limits
// ****************************************
`define STATUS_VALID_MASK 32'h83BF_EFFF
`define STATUS_CLEAR_MASK 32'h83BB_EFFF
`define STATUS_RESET      32'h0000_0000
`define ENABLE_RESET      32'h0000_0000
`define BYTE_TEST_VALUE   32'h8765_4321
`define DROP_MID_FROM     32'h7FFF_FFFF
`define DROP_MID_TO       32'h8000_0000
`define TIMER_WRAP_FROM   16'h0000
`define TIMER_WRAP_TO     16'hFFFF
`define RX_WDOG_BYTES     16'h0800

`endif

/* File: verilog/wrap_detect.v */
`timescale 1ns/1ps
// Flags a counter step from one exact value to another
module wrap_detect #(
	parameter             WIDTH    = 16,
	parameter [WIDTH-1:0] FROM_VAL = {WIDTH{1'b0}},
	parameter [WIDTH-1:0] TO_VAL   = {WIDTH{1'b1}}
) (
	// Clock and reset
	input  wire             core_clk,
	input  wire             rst_n,
	// Watched counter
	input  wire [WIDTH-1:0] value,
	output wire             hit
);
	reg [WIDTH-1:0] prev_q;
	reg             armed_q;

	// Previous sample; armed so the reset value cannot fake a step
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q  <= {WIDTH{1'b0}};
			armed_q <= 1'b0;
		end else begin
			prev_q  <= value;
			armed_q <= 1'b1;
		end
	end

	assign hit = armed_q && (prev_q == FROM_VAL) && (value == TO_VAL);
endmodule

/* File: verilog/pin_event_detect.v */
`timescale 1ns/1ps
// Per-pin edge events, edge choice per pin
module pin_event_detect #(
	parameter PINS = 3
) (
	// Clock and reset
	input  wire            core_clk,
	input  wire            rst_n,
	// Pins and their edge selection
	input  wire [PINS-1:0] pin_level,
	input  wire [PINS-1:0] rise_en,
	input  wire [PINS-1:0] fall_en,
	output wire [PINS-1:0] pin_event
);
	reg [PINS-1:0] prev_q;
	reg            armed_q;

	// Last pin levels
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q  <= {PINS{1'b0}};
			armed_q <= 1'b0;
		end else begin
			prev_q  <= pin_level;
			armed_q <= 1'b1;
		end
	end

	genvar i;
	generate
		for (i = 0; i < PINS; i = i + 1) begin : g_pin
			// Either selected edge counts as an event
			assign pin_event[i] = armed_q &
				((rise_en[i] & pin_level[i] & ~prev_q[i]) |
				 (fall_en[i] & ~pin_level[i] & prev_q[i]));
		end
	endgenerate
endmodule

/* File: verilog/int_status.v */
`timescale 1ns/1ps
`include "int_status_regs.vh"

// Interrupt status register with enable mask, byte test and wake request
module int_status #(
	parameter GPIO_PINS = 3,
	parameter DMA_WIDTH = 12,
	parameter LEN_WIDTH = 16
) (
	// Clock and reset
	input  wire                 core_clk,
	input  wire                 rst_n,

	// Host bus, synchronous strobes
	input  wire [7:0]           host_addr,
	input  wire                 host_wr,
	input  wire                 host_rd,
	input  wire [31:0]          host_wdata,
	output reg  [31:0]          host_rdata_q,

	// Transmit engine
	input  wire                 tx_stop_request,
	input  wire                 tx_halted,
	input  wire                 tx_error,
	input  wire                 tx_underrun,
	input  wire                 tx_buffer_loaded,
	input  wire                 completion_notify_flag,

	// Transmit FIFOs
	input  wire                 tx_data_write,
	input  wire                 tx_data_full,
	input  wire [7:0]           tx_free_space,
	input  wire [7:0]           tx_space_level,
	input  wire                 tx_status_overflow,
	input  wire                 tx_status_full,
	input  wire [7:0]           tx_status_used,
	input  wire [7:0]           tx_status_level,

	// Receive engine
	input  wire                 rx_halted,
	input  wire                 rx_error,
	input  wire                 rx_frame_done,
	input  wire [LEN_WIDTH-1:0] rx_frame_len,
	input  wire                 rx_frame_dropped,
	input  wire [31:0]          rx_drop_count,

	// Receive FIFOs and DMA
	input  wire                 rx_data_pop,
	input  wire [DMA_WIDTH-1:0] receive_dma_count,
	input  wire [7:0]           rx_free_space,
	input  wire [7:0]           rx_space_level,
	input  wire                 rx_status_full,
	input  wire [7:0]           rx_status_used,
	input  wire [7:0]           rx_status_level,

	// Timer, PHY, power, GPIO
	input  wire [15:0]          timer_count,
	input  wire                 phy_event,
	input  wire                 power_event,
	input  wire [GPIO_PINS-1:0] gpio_pin,
	input  wire [GPIO_PINS-1:0] gpio_rise_en,
	input  wire [GPIO_PINS-1:0] gpio_fall_en,

	// Results
	output reg                  irq_master_q,
	output reg                  wake_request_q,
	output reg  [31:0]          status_q
);

	// ****************************************
	// Address decode
	// ****************************************

	// Decode shared by read and write paths
	function is_reg;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			is_reg = (addr == ofs);
		end
	endfunction

	// Strict greater-than shared by every FIFO level test
	function above;
		input [7:0] val;
		input [7:0] lim;
		begin
			above = (val > lim);
		end
	endfunction

	wire wr_status = host_wr && is_reg(host_addr, `OFS_INTERRUPT_STATUS);
	wire wr_enable = host_wr && is_reg(host_addr, `OFS_INTERRUPT_ENABLE);
	wire wr_byte   = host_wr && is_reg(host_addr, `OFS_BYTE_TEST);

	// ****************************************
	// Enable mask
	// ****************************************

	reg [31:0] enable_q;

	// Mask shapes the master line; of the flags, only bit 31 follows it
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_q <= `ENABLE_RESET;
		end else if (wr_enable) begin
			enable_q <= host_wdata & `STATUS_VALID_MASK;
		end
	end

	// ****************************************
	// Counter step detectors
	// ****************************************

	wire drop_mid_hit;
	wire timer_wrap_hit;
	wire [GPIO_PINS-1:0] gpio_event;

	// Dropped-frame counter crossing its midpoint
	wrap_detect #(
		.WIDTH    (32),
		.FROM_VAL (`DROP_MID_FROM),
		.TO_VAL   (`DROP_MID_TO)
	) u_drop_mid (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.value    (rx_drop_count),
		.hit      (drop_mid_hit)
	);

	// Down counter passing zero to all ones
	wrap_detect #(
		.WIDTH    (16),
		.FROM_VAL (`TIMER_WRAP_FROM),
		.TO_VAL   (`TIMER_WRAP_TO)
	) u_timer_wrap (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.value    (timer_count),
		.hit      (timer_wrap_hit)
	);

	// GPIO edges as chosen by the pin configuration
	pin_event_detect #(
		.PINS      (GPIO_PINS)
	) u_pins (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.pin_level (gpio_pin),
		.rise_en   (gpio_rise_en),
		.fall_en   (gpio_fall_en),
		.pin_event (gpio_event)
	);

	// ****************************************
	// Level conditions to events
	// ****************************************

	// Levels turned into single events so an ack is not instantly undone
	localparam NLVL = 8;
	wire [NLVL-1:0] lvl_now;
	reg  [NLVL-1:0] lvl_q;
	wire [NLVL-1:0] lvl_rise;

	assign lvl_now[0] = tx_stop_request & tx_halted;
	assign lvl_now[1] = rx_halted;
	assign lvl_now[2] = above(tx_free_space, tx_space_level);
	assign lvl_now[3] = tx_status_full;
	assign lvl_now[4] = above(tx_status_used, tx_status_level);
	assign lvl_now[5] = above(rx_space_level, rx_free_space);
	assign lvl_now[6] = rx_status_full;
	assign lvl_now[7] = above(rx_status_used, rx_status_level);

	// Previous levels
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lvl_q <= {NLVL{1'b0}};
		end else begin
			lvl_q <= lvl_now;
		end
	end

	assign lvl_rise = lvl_now & ~lvl_q;

	// ****************************************
	// Software event
	// ****************************************

	wire sw_event;

	// Level on purpose: the flag stays set through an ack while the enable stays high
	assign sw_event = enable_q[`BIT_SOFTWARE];

	// ****************************************
	// Receive watchdog
	// ****************************************

	wire rx_too_long;

	// Length only counts in the frame-done cycle
	assign rx_too_long = rx_frame_done && (rx_frame_len > `RX_WDOG_BYTES);

	// ****************************************
	// Receive DMA progress
	// ****************************************

	reg  [DMA_WIDTH-1:0] dma_moved_q;
	wire [DMA_WIDTH-1:0] dma_moved_inc;
	wire                 dma_done;

	assign dma_moved_inc = dma_moved_q + {{(DMA_WIDTH-1){1'b0}}, 1'b1};
	// A zero count never completes, so DMA is off
	assign dma_done = rx_data_pop && (receive_dma_count != {DMA_WIDTH{1'b0}})
		&& (dma_moved_inc == receive_dma_count);

	// Count words leaving the receive FIFO, restart after each completion
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dma_moved_q <= {DMA_WIDTH{1'b0}};
		end else if (dma_done) begin
			dma_moved_q <= {DMA_WIDTH{1'b0}};
		end else if (rx_data_pop) begin
			dma_moved_q <= dma_moved_inc;
		end
	end

	// ****************************************
	// Event vector
	// ****************************************

	reg [31:0] ev_set;

	// One bit per source, all but the PHY bit gathered here
	always @* begin
		ev_set                 = 32'h0000_0000;
		ev_set[`BIT_SOFTWARE]  = sw_event;
		ev_set[`BIT_TX_HALT]   = lvl_rise[0];
		ev_set[`BIT_RX_HALT]   = lvl_rise[1];
		ev_set[`BIT_DROP_MID]  = drop_mid_hit;
		ev_set[`BIT_BUF_LOAD]  = tx_buffer_loaded & completion_notify_flag;
		ev_set[`BIT_RX_DMA]    = dma_done;
		ev_set[`BIT_TIMER]     = timer_wrap_hit;
		ev_set[`BIT_POWER]     = power_event;
		ev_set[`BIT_TXS_OVF]   = tx_status_overflow;
		ev_set[`BIT_RX_WDOG]   = rx_too_long;
		ev_set[`BIT_RX_ERR]    = rx_error;
		ev_set[`BIT_TX_ERR]    = tx_error;
		ev_set[`BIT_TX_UNDER]  = tx_underrun;
		ev_set[`BIT_TX_OVER]   = tx_data_write & tx_data_full;
		ev_set[`BIT_TX_SPACE]  = lvl_rise[2];
		ev_set[`BIT_TXS_FULL]  = lvl_rise[3];
		ev_set[`BIT_RXS_FULL]  = lvl_rise[6];
		ev_set[`BIT_TXS_LEVEL] = lvl_rise[4];
		ev_set[`BIT_RXD_LEVEL] = lvl_rise[5];
		ev_set[`BIT_RXS_LEVEL] = lvl_rise[7];
		ev_set[`BIT_RX_DROP]   = rx_frame_dropped;
		ev_set[GPIO_PINS-1:0]  = gpio_event;
	end

	// ****************************************
	// Status register
	// ****************************************

	wire [31:0] clr_bits;
	reg  [31:0] status_d;

	// Ones clear, zeros leave alone; the PHY bit cannot be cleared
	assign clr_bits = wr_status ? (host_wdata & `STATUS_CLEAR_MASK)
		: 32'h0000_0000;

	// Set beats clear so an event in the ack cycle survives
	always @* begin
		status_d = ((status_q & ~clr_bits) | ev_set)
			& `STATUS_VALID_MASK;
		status_d[`BIT_PHY] = phy_event;
	end

	// Sticky flags but PHY bit 18; only the software flag depends on the enable mask
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= `STATUS_RESET;
		end else begin
			status_q <= status_d;
		end
	end

	// ****************************************
	// Master indication
	// ****************************************

	wire [31:0] pending;

	// Enabled flags only; the mask reaches no flag but the software flag
	assign pending = status_q & enable_q;

	// Follows the status register one cycle later, from a flop
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_master_q <= 1'b0;
		end else begin
			irq_master_q <= |pending;
		end
	end

	// ****************************************
	// Wake request
	// ****************************************

	// Only a byte test write wakes; power events are left out on purpose
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_request_q <= 1'b0;
		end else begin
			wake_request_q <= wr_byte;
		end
	end

	// ****************************************
	// Read path
	// ****************************************

	reg [31:0] rd_mux;

	// Unmapped offsets read as zero
	always @* begin
		rd_mux = 32'h0000_0000;
		if (is_reg(host_addr, `OFS_INTERRUPT_STATUS)) begin
			rd_mux = status_q;
		end else if (is_reg(host_addr, `OFS_INTERRUPT_ENABLE)) begin
			rd_mux = enable_q;
		end else if (is_reg(host_addr, `OFS_BYTE_TEST)) begin
			rd_mux = `BYTE_TEST_VALUE;
		end
	end

	// Data registered one cycle after the read strobe and held
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_rdata_q <= 32'h0000_0000;
		end else if (host_rd) begin
			host_rdata_q <= rd_mux;
		end
	end

endmodule

/* File: tb/int_status_asserts.sv */
`timescale 1ns/1ps
`include "int_status_regs.vh"
module int_status_asserts (
	// Clock and reset
	input wire        core_clk,
	input wire        rst_n,
	// Host bus
	input wire [7:0]  host_addr,
	input wire        host_wr,
	input wire [31:0] host_wdata,
	// Sources
	input wire        rx_error,
	input wire        power_event,
	input wire        phy_event,
	// Results
	input wire        irq_master_q,
	input wire        wake_request_q,
	input wire [31:0] status_q
);
	reg [31:0] en_q;

	// Shadow of the enable mask, the checker sees no internal state
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= 32'h0000_0000;
		end else if (host_wr && host_addr == `OFS_INTERRUPT_ENABLE) begin
			en_q <= host_wdata;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ****************************************
	// Properties
	// ****************************************
	sequence st_write_s(int b);
		host_wr && host_addr == `OFS_INTERRUPT_STATUS && host_wdata[b];
	endsequence

	rx_err_set_a: assert property (rx_error |=> status_q[`BIT_RX_ERR])
		else $error("receive error flag missed");
	power_set_a: assert property (power_event |=> status_q[`BIT_POWER])
		else $error("power event flag missed");
	rx_clear_a: assert property (st_write_s(`BIT_RX_ERR) ##0 !rx_error |=> !status_q[14])
		else $error("receive error flag not cleared");
	flag_hold_a: assert property (status_q[14] && !(host_wr && host_wdata[14]) |=> status_q[14])
		else $error("receive error flag dropped");
	phy_follow_a: assert property ($past(rst_n, 2) |-> status_q[`BIT_PHY] == $past(phy_event))
		else $error("phy flag not following source");
	reserved_zero_a: assert property ((status_q & ~`STATUS_VALID_MASK) == 32'h0000_0000)
		else $error("reserved status bit set");
	irq_mask_a: assert property (irq_master_q == $past(|(status_q & en_q)))
		else $error("master indication wrong");
	wake_pulse_a: assert property (wake_request_q == $past(host_wr && host_addr == 8'h64))
		else $error("wake request wrong");
	sw_set_a: assert property (en_q[31] |=> status_q[`BIT_SOFTWARE])
		else $error("software flag missed");
endmodule

bind int_status int_status_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n),
	.host_addr(host_addr), .host_wr(host_wr), .host_wdata(host_wdata),
	.rx_error(rx_error), .power_event(power_event), .phy_event(phy_event),
	.irq_master_q(irq_master_q), .wake_request_q(wake_request_q), .status_q(status_q));

/* File: tb/host_cpu_model.sv */
`timescale 1ns/1ps
module host_cpu_model (
	// Clock
	input  wire        core_clk,
	// Bus toward the device
	output reg  [7:0]  host_addr,
	output reg         host_wr,
	output reg         host_rd,
	output reg  [31:0] host_wdata,
	input  wire [31:0] host_rdata_q
);
	// Idle bus at time zero
	initial begin
		host_addr = 8'h00;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_wdata = 32'h0000_0000;
	end

	// One write strobe; a one in a flag position acknowledges it
	task write_word(input [7:0] a, input [31:0] d);
		begin
			host_addr = a;
			host_wdata = d;
			host_wr = 1'b1;
			@(posedge core_clk);
			#1;
			host_wr = 1'b0;
			host_wdata = ~d; // Stale data must not look valid
		end
	endtask

	// One read strobe, data taken a cycle after it is loaded
	task read_word(input [7:0] a, output [31:0] d);
		begin
			host_addr = a;
			host_rd = 1'b1;
			@(posedge core_clk);
			#1;
			host_rd = 1'b0;
			@(posedge core_clk);
			#1;
			d = host_rdata_q;
		end
	endtask
endmodule

/* File: tb/ethernet_interrupt_status_tb_top.sv */
`timescale 1ns/1ps
`include "int_status_regs.vh"
module ethernet_interrupt_status_tb_top;
	reg         core_clk;
	reg         rst_n;
	reg  [15:0] ev;
	reg  [63:0] lvl;
	reg  [31:0] drop;
	reg  [15:0] tmr;
	reg  [15:0] flen;
	reg  [11:0] dma;
	reg         fdone;
	reg         pop;
	reg  [8:0]  gp;
	reg  [31:0] rd;
	wire [7:0]  host_addr;
	wire        host_wr;
	wire        host_rd;
	wire [31:0] host_wdata;
	wire [31:0] host_rdata_q;
	wire        irq_master_q;
	wire        wake_request_q;
	wire [31:0] status_q;
	integer     num_errors;
	integer     compares;

	host_cpu_model u_host (.core_clk(core_clk), .host_addr(host_addr), .host_wr(host_wr),
		.host_rd(host_rd), .host_wdata(host_wdata), .host_rdata_q(host_rdata_q));

	int_status u_dut (.core_clk(core_clk), .rst_n(rst_n), .host_addr(host_addr),
		.host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
		.host_rdata_q(host_rdata_q), .tx_error(ev[0]), .tx_underrun(ev[1]),
		.tx_status_overflow(ev[2]), .rx_error(ev[3]), .rx_frame_dropped(ev[4]),
		.power_event(ev[5]), .tx_buffer_loaded(ev[6]), .completion_notify_flag(ev[7]),
		.tx_data_write(ev[8]), .tx_data_full(ev[9]), .tx_stop_request(ev[10]),
		.tx_halted(ev[11]), .rx_halted(ev[12]), .tx_status_full(ev[13]),
		.rx_status_full(ev[14]), .phy_event(ev[15]), .tx_free_space(lvl[7:0]),
		.tx_space_level(lvl[15:8]), .tx_status_used(lvl[23:16]),
		.tx_status_level(lvl[31:24]), .rx_free_space(lvl[39:32]),
		.rx_space_level(lvl[47:40]), .rx_status_used(lvl[55:48]),
		.rx_status_level(lvl[63:56]), .rx_drop_count(drop), .timer_count(tmr),
		.rx_frame_done(fdone), .rx_frame_len(flen), .rx_data_pop(pop),
		.receive_dma_count(dma), .gpio_pin(gp[2:0]), .gpio_rise_en(gp[5:3]),
		.gpio_fall_en(gp[8:6]), .irq_master_q(irq_master_q),
		.wake_request_q(wake_request_q), .status_q(status_q));

	// Free running core clock
	always #5 core_clk = ~core_clk;

	// ****************************************
	// Helpers
	// ****************************************
	task print_verdict;
		begin
			if (num_errors == 0 && compares > 0) begin
				$display("RESULT: PASS");
			end else begin
				$display("RESULT: FAIL");
			end
			$finish;
		end
	endtask

	task chk(input [31:0] got, input [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask

	// Lets the detector and flag stages settle
	task settle;
		begin
			repeat (3) @(posedge core_clk);
			#1;
		end
	endtask

	// Source mask high for one cycle, flag check, then acknowledge all
	task ev_case(input [15:0] m, input [31:0] exp);
		begin
			ev = m;
			@(posedge core_clk);
			#1;
			ev = 16'h0000;
			settle;
			chk(status_q, exp);
			u_host.write_word(`OFS_INTERRUPT_STATUS, 32'hFFFF_FFFF);
			chk(status_q, 32'h0000_0000);
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task s_events;
		begin
			ev_case(16'h0001, 32'h0000_2000);
			ev_case(16'h0002, 32'h0000_0800);
			ev_case(16'h0004, 32'h0001_0000);
			ev_case(16'h0008, 32'h0000_4000);
			ev_case(16'h0010, 32'h0000_0040);
			ev_case(16'h0020, 32'h0002_0000);
			ev_case(16'h00C0, 32'h0020_0000);
			ev_case(16'h0040, 32'h0000_0000);
			ev_case(16'h0300, 32'h0000_0400);
			ev_case(16'h0C00, 32'h0200_0000);
			ev_case(16'h0800, 32'h0000_0000);
			ev_case(16'h1000, 32'h0100_0000);
			ev_case(16'h6000, 32'h0000_0110);
		end
	endtask

	task s_counts;
		begin
			drop = 32'h7FFF_FFFF;
			tmr = 16'h0001;
			settle;
			drop = 32'h8000_0000;
			tmr = 16'h0000;
			settle;
			chk(status_q, 32'h0080_0000);
			tmr = 16'hFFFF;
			settle;
			chk(status_q, 32'h0088_0000);
			lvl = 64'h0404_1010_0303_2020; // Equal levels must not fire
			settle;
			chk(status_q, 32'h0088_0000);
			lvl = 64'h0405_100F_0304_2021;
			settle;
			chk(status_q, 32'h0088_02A8);
			ev_case(16'h0000, 32'h0088_02A8);
		end
	endtask

	task s_rx_path;
		begin
			flen = 16'h0800;
			fdone = 1'b1;
			@(posedge core_clk);
			#1;
			flen = 16'h0801;
			@(posedge core_clk);
			#1;
			fdone = 1'b0;
			dma = 12'h003;
			pop = 1'b1;
			repeat (2) @(posedge core_clk);
			#1;
			pop = 1'b0;
			settle;
			chk(status_q, 32'h0000_8000);
			pop = 1'b1;
			ev_case(16'h0000, 32'h0010_8000);
			pop = 1'b0;
		end
	endtask

	task s_gpio;
		begin
			gp = 9'b010_001_000;
			settle;
			gp = 9'b010_001_011;
			settle;
			chk(status_q, 32'h0000_0001);
			gp = 9'b010_001_000;
			settle;
			chk(status_q, 32'h0000_0003);
			u_host.write_word(`OFS_INTERRUPT_STATUS, 32'h0000_0001);
			chk(status_q, 32'h0000_0002);
			ev_case(16'h0000, 32'h0000_0002);
			gp = 9'b100_100_100;
			settle;
			chk(status_q, 32'h0000_0004);
			u_host.write_word(`OFS_INTERRUPT_STATUS, 32'h0000_0004);
			chk(status_q, 32'h0000_0000);
			gp = 9'b100_100_000;
			ev_case(16'h0000, 32'h0000_0004);
		end
	endtask

	task s_sw_irq;
		begin
			u_host.write_word(`OFS_INTERRUPT_ENABLE, 32'h8000_0000);
			settle;
			chk(status_q, 32'h8000_0000);
			chk({31'h0, irq_master_q}, 32'h1);
			u_host.write_word(`OFS_INTERRUPT_ENABLE, 32'h0000_4000);
			ev_case(16'h0000, 32'h8000_0000);
			chk({31'h0, irq_master_q}, 32'h0);
			ev = 16'h0008;
			@(posedge core_clk);
			#1;
			ev = 16'h0000;
			settle;
			chk({31'h0, irq_master_q}, 32'h1);
			ev_case(16'h0000, 32'h0000_4000);
			settle;
			chk({31'h0, irq_master_q}, 32'h0);
		end
	endtask

	task s_phy_bus;
		begin
			ev = 16'h8020;
			settle;
			ev = 16'h8000;
			chk({31'h0, wake_request_q}, 32'h0);
			u_host.write_word(`OFS_INTERRUPT_STATUS, 32'hFFFF_FFFF);
			settle;
			u_host.read_word(`OFS_INTERRUPT_STATUS, rd);
			chk(rd, 32'h0004_0000);
			ev = 16'h0000;
			settle;
			chk(status_q, 32'h0000_0000);
			u_host.write_word(`OFS_BYTE_TEST, 32'h0000_0000);
			chk({31'h0, wake_request_q}, 32'h1);
			@(posedge core_clk);
			#1;
			chk({31'h0, wake_request_q}, 32'h0);
			u_host.read_word(8'h64, rd);
			chk(rd, `BYTE_TEST_VALUE);
			u_host.read_word(8'h70, rd);
			chk(rd, 32'h0000_0000);
		end
	endtask

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors = num_errors + 1;
		print_verdict;
	end

	// Main sequence
	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		ev = 16'h0000;
		lvl = 64'h0000_0000_0000_0000;
		drop = 32'h0000_0000;
		tmr = 16'h0005;
		flen = 16'h0000;
		dma = 12'h000;
		fdone = 1'b0;
		pop = 1'b0;
		gp = 9'b000_000_000;
		num_errors = 0;
		compares = 0;
		repeat (10) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		settle;
		chk(status_q, `STATUS_RESET);
		s_events;
		s_counts;
		s_rx_path;
		s_gpio;
		s_sw_irq;
		s_phy_bus;
		print_verdict;
	end
endmodule
